// *** logic/rrcr_pkg.sv ***
package rrcr_pkg;
    // connection slots held on chip
    localparam int          NCONN      = 4;
    localparam int          CW         = 2;
    // apb register offsets (byte addresses)
    localparam logic [11:0] OFS_CTRL   = 12'h0000;
    localparam logic [11:0] OFS_STAT   = 12'h0004;
    localparam logic [11:0] OFS_AIDX   = 12'h0008;
    localparam logic [11:0] OFS_ADAT   = 12'h000C;
    localparam logic [11:0] OFS_CBASE  = 12'h0010;
    localparam logic [11:0] OFS_TBASE  = 12'h0020;
    localparam logic [11:0] OFS_PCNT   = 12'h0030;
    localparam logic [11:0] OFS_OCNT   = 12'h0040;
    localparam logic [11:0] OFS_SPLIT  = 12'h0080;
    localparam logic [11:0] OFS_RTBL   = 12'h0400;
    // protocol figures
    localparam logic [1:0]  RTP_VER    = 2'h2;
    localparam logic [15:0] LEN_SAT    = 16'h00FF;
    localparam int          CHAN_SHIFT = 5;
    localparam int          TBL_SHIFT  = 10;
    // split entry fields
    localparam int          SPL_REP    = 0;
    localparam int          SPL_TYP    = 1;
    localparam int          SPL_ENC    = 4;
    localparam int          SPL_PTR    = 8;
    // channel type codes
    localparam logic [2:0]  TYP_PCM    = 3'h0;
    localparam logic [2:0]  TYP_HDLC   = 3'h1;
    localparam logic [2:0]  TYP_CPU    = 3'h2;
    localparam logic [2:0]  TYP_DEL    = 3'h7;
    // voice encoding codes
    localparam logic [3:0]  ENC_PCM    = 4'h0;
    localparam logic [3:0]  ENC_AD40   = 4'h1;
    localparam logic [3:0]  ENC_AD32   = 4'h2;
    localparam logic [3:0]  ENC_AD24   = 4'h3;
    localparam logic [3:0]  ENC_AD16   = 4'h4;
    localparam logic [3:0]  ENC_SIDI   = 4'h5;
    localparam logic [3:0]  ENC_ULA    = 4'h8;
    localparam logic [3:0]  ENC_ALU    = 4'h9;
    localparam logic [3:0]  ENC_ALU0   = 4'hA;
    localparam logic [3:0]  ENC_UUL0   = 4'hB;
    localparam logic [3:0]  ENC_SIDE   = 4'hC;

    typedef enum logic [2:0] {
        KIND_PCM, KIND_HDLC, KIND_CPU, KIND_DEL, KIND_RSV
    } rrcr_kind_t;

    typedef enum logic [3:0] {
        VE_PCM, VE_AD40, VE_AD32, VE_AD24, VE_AD16, VE_SID_INT,
        VE_U2A, VE_A2U, VE_A2U_NZ, VE_U2U_NZ, VE_SID_EXT, VE_RSV
    } rrcr_enc_t;
endpackage

// *** logic/rrcr_top.sv ***
`timescale 1ns/1ps
// Behaviour
// - rtp packets with errors, first packet, loss or report request produce an event
// - rtp record holds marker/type or udp length, sequence numbers and timestamp
// - first packet on a connection sets the first-packet flag
// - non-incrementing rtp sequence sets loss flag; both numbers recorded
// - report flag follows report bit of the selected split entry unless the packet is short
// - too-short packet raises short flag and is discarded
// - rtp version other than 2 raises version-mismatch flag
// - failed udp checksum raises checksum-error flag
// - rtp record carries the connection structure base address
// - udp payload length in the record saturates at 255
// - aal2 uui and li form an 11-bit index into a 2048-entry table
// - classify table address is table-base pointer times 1024
// - table entry picks one of 16 split entries
// - aal2 packet counter increments by one per packet
// - aal2 octet counter adds li plus one per cps packet
// - split report bit sends uui/li combination to the event queue
// - 3-bit channel type decode: pcm, hdlc, cpu queue, delete, reserved
// - 4-bit voice encoding decode: pcm, adpcm rates, sid, law conversions
// - channel structure address is split pointer times 32
// - aal2 records flag only first packet and report; carry uui, li, base, timestamp
module rrcr_top (
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 pkt_valid,
    output logic                      pkt_ready,
    input  wire logic                 pkt_aal2,
    input  wire logic                 pkt_rtp_en,
    input  wire logic [1:0]           pkt_conn,
    input  wire logic                 pkt_csum_err,
    input  wire logic [1:0]           pkt_rtp_ver,
    input  wire logic                 pkt_len_short,
    input  wire logic                 pkt_marker,
    input  wire logic [6:0]           pkt_ptype,
    input  wire logic [15:0]          pkt_udp_len,
    input  wire logic [15:0]          pkt_seq,
    input  wire logic [4:0]           pkt_uui,
    input  wire logic [5:0]           pkt_li,
    input  wire logic [31:0]          local_ts,
    output logic                      evt_valid,
    input  wire logic                 evt_ready,
    output logic                      evt_aal2,
    output logic                      evt_first,
    output logic                      evt_loss,
    output logic                      evt_report,
    output logic                      evt_short,
    output logic                      evt_ver,
    output logic                      evt_csum,
    output logic      [31:0]          evt_conn_addr,
    output logic      [7:0]           evt_mpt,
    output logic      [15:0]          evt_prev_seq,
    output logic      [15:0]          evt_cur_seq,
    output logic      [4:0]           evt_uui,
    output logic      [5:0]           evt_li,
    output logic      [31:0]          evt_ts,
    output logic                      chan_valid,
    output logic      [31:0]          chan_addr,
    output rrcr_pkg::rrcr_kind_t      chan_kind,
    output rrcr_pkg::rrcr_enc_t       chan_enc,
    output logic      [31:0]          class_addr
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    // channel type, used for the output and for the discard of deleted splits
    function automatic rrcr_pkg::rrcr_kind_t f_kind(input logic [2:0] t);
        if (t == rrcr_pkg::TYP_PCM)       f_kind = rrcr_pkg::KIND_PCM;
        else if (t == rrcr_pkg::TYP_HDLC) f_kind = rrcr_pkg::KIND_HDLC;
        else if (t == rrcr_pkg::TYP_CPU)  f_kind = rrcr_pkg::KIND_CPU;
        else if (t == rrcr_pkg::TYP_DEL)  f_kind = rrcr_pkg::KIND_DEL;
        else                              f_kind = rrcr_pkg::KIND_RSV;
    endfunction

    function automatic rrcr_pkg::rrcr_enc_t f_enc(input logic [3:0] e);
        case (e)
            rrcr_pkg::ENC_PCM:  f_enc = rrcr_pkg::VE_PCM;
            rrcr_pkg::ENC_AD40: f_enc = rrcr_pkg::VE_AD40;
            rrcr_pkg::ENC_AD32: f_enc = rrcr_pkg::VE_AD32;
            rrcr_pkg::ENC_AD24: f_enc = rrcr_pkg::VE_AD24;
            rrcr_pkg::ENC_AD16: f_enc = rrcr_pkg::VE_AD16;
            rrcr_pkg::ENC_SIDI: f_enc = rrcr_pkg::VE_SID_INT;
            rrcr_pkg::ENC_ULA:  f_enc = rrcr_pkg::VE_U2A;
            rrcr_pkg::ENC_ALU:  f_enc = rrcr_pkg::VE_A2U;
            rrcr_pkg::ENC_ALU0: f_enc = rrcr_pkg::VE_A2U_NZ;
            rrcr_pkg::ENC_UUL0: f_enc = rrcr_pkg::VE_U2U_NZ;
            rrcr_pkg::ENC_SIDE: f_enc = rrcr_pkg::VE_SID_EXT;
            default:            f_enc = rrcr_pkg::VE_RSV;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic              en_reg;
    logic [10:0]       aidx_reg;
    logic [31:0]       cbase_reg [rrcr_pkg::NCONN];
    logic [21:0]       tbase_reg [rrcr_pkg::NCONN];
    logic [15:0]       pcnt_reg  [rrcr_pkg::NCONN];
    logic [31:0]       ocnt_reg  [rrcr_pkg::NCONN];
    logic [15:0]       lseq_reg  [rrcr_pkg::NCONN];
    logic              init_reg  [rrcr_pkg::NCONN];
    logic [31:0]       split_reg [16];
    logic [3:0]        rtbl_mem  [256];
    logic [3:0]        atbl_mem  [2048];
    logic              evt_next;
    logic              acc;

    ////////////////////////////////////////////////////////////////////////////
    // packet classification

    wire        is_rtp   = !pkt_aal2;
    wire [10:0] aidx     = {pkt_uui, pkt_li};
    wire [15:0] len_sat  = (pkt_udp_len > rrcr_pkg::LEN_SAT) ? rrcr_pkg::LEN_SAT
                                                             : pkt_udp_len;
    wire [7:0]  mpt      = pkt_rtp_en ? {pkt_marker, pkt_ptype} : len_sat[7:0];
    wire [3:0]  sidx     = pkt_aal2 ? atbl_mem[aidx] : rtbl_mem[mpt];
    wire [31:0] split    = split_reg[sidx];
    wire        f_short  = is_rtp && pkt_len_short;
    wire        f_ver    = is_rtp && pkt_rtp_en && (pkt_rtp_ver != rrcr_pkg::RTP_VER);
    wire        f_csum   = is_rtp && pkt_csum_err;
    wire        f_first  = !init_reg[pkt_conn];
    wire        f_loss   = is_rtp && pkt_rtp_en && !f_first && !f_short
                           && (pkt_seq != lseq_reg[pkt_conn] + 16'h0001);
    wire        f_rep    = split[rrcr_pkg::SPL_REP] && !f_short;
    // one record gathers every flag of the packet
    wire        gen      = f_short | f_ver | f_csum | f_first | f_loss | f_rep;
    wire [6:0]  li_inc   = {1'b0, pkt_li} + 7'h01;
    wire [31:0] oct_add  = pkt_aal2 ? {25'h000_0000, li_inc} : {16'h0000, pkt_udp_len};
    wire [2:0]  typ      = split[rrcr_pkg::SPL_ENC-1:rrcr_pkg::SPL_TYP];
    wire [3:0]  enc      = split[rrcr_pkg::SPL_PTR-1:rrcr_pkg::SPL_ENC];
    wire [23:0] cptr     = split[31:rrcr_pkg::SPL_PTR];

    // a pending record blocks intake, so records keep packet order
    assign acc      = pkt_valid && pkt_ready && en_reg;
    assign evt_next = (acc && gen) ? 1'b1 : (evt_ready ? 1'b0 : evt_valid);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            evt_valid <= 1'b0;
            pkt_ready <= 1'b0;
        end else begin
            evt_valid <= evt_next;
            pkt_ready <= !evt_next;
        end
    end

    // record capture: aal2 records only ever carry first and report flags
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            {evt_aal2, evt_first, evt_loss, evt_report} <= 4'h0;
            {evt_short, evt_ver, evt_csum}              <= 3'h0;
            evt_conn_addr <= 32'h0000_0000;
            evt_mpt       <= 8'h00;
            evt_prev_seq  <= 16'h0000;
            evt_cur_seq   <= 16'h0000;
            evt_uui       <= 5'h00;
            evt_li        <= 6'h00;
            evt_ts        <= 32'h0000_0000;
        end else if (acc && gen) begin
            evt_aal2      <= pkt_aal2;
            evt_first     <= f_first;
            evt_loss      <= f_loss;
            evt_report    <= f_rep;
            evt_short     <= f_short;
            evt_ver       <= f_ver;
            evt_csum      <= f_csum;
            evt_conn_addr <= cbase_reg[pkt_conn];
            evt_mpt       <= mpt;
            evt_prev_seq  <= lseq_reg[pkt_conn];
            evt_cur_seq   <= pkt_seq;
            evt_uui       <= pkt_uui;
            evt_li        <= pkt_li;
            evt_ts        <= local_ts;
        end
    end

    // steering: short packets and deleted splits go nowhere
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            chan_valid <= 1'b0;
            chan_addr  <= 32'h0000_0000;
            chan_kind  <= rrcr_pkg::KIND_PCM;
            chan_enc   <= rrcr_pkg::VE_PCM;
            class_addr <= 32'h0000_0000;
        end else begin
            chan_valid <= acc && !f_short && f_kind(typ) != rrcr_pkg::KIND_DEL;
            if (acc) begin
                chan_addr <= {3'h0, cptr, {rrcr_pkg::CHAN_SHIFT{1'b0}}};
                chan_kind <= f_kind(typ);
                chan_enc  <= f_enc(enc);
                // 4-bit entries: byte offset is index / 2 inside the 1k table
                class_addr <= {tbase_reg[pkt_conn], aidx[10:1]};
            end
        end
    end

    // per-connection state; a short packet leaves it untouched, a deleted split still updates it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < rrcr_pkg::NCONN; i++) begin
                pcnt_reg[i] <= 16'h0000;
                ocnt_reg[i] <= 32'h0000_0000;
                lseq_reg[i] <= 16'h0000;
                init_reg[i] <= 1'b0;
            end
        end else if (acc && !f_short) begin
            pcnt_reg[pkt_conn] <= pcnt_reg[pkt_conn] + 16'h0001;
            ocnt_reg[pkt_conn] <= ocnt_reg[pkt_conn] + oct_add;
            init_reg[pkt_conn] <= 1'b1;
            if (is_rtp && pkt_rtp_en) begin
                lseq_reg[pkt_conn] <= pkt_seq;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave, one wait state

    wire        ap_acc  = psel && penable;
    wire        ap_wr   = ap_acc && pready && pwrite;
    wire [1:0]  rslot   = paddr[3:2];
    wire [3:0]  sslot   = paddr[5:2];
    wire        hit_cb  = paddr[11:4] == rrcr_pkg::OFS_CBASE[11:4];
    wire        hit_tb  = paddr[11:4] == rrcr_pkg::OFS_TBASE[11:4];
    wire        hit_pc  = paddr[11:4] == rrcr_pkg::OFS_PCNT[11:4];
    wire        hit_oc  = paddr[11:4] == rrcr_pkg::OFS_OCNT[11:4];
    wire        hit_sp  = paddr[11:6] == rrcr_pkg::OFS_SPLIT[11:6];
    wire        hit_rt  = paddr[11:10] == rrcr_pkg::OFS_RTBL[11:10];
    logic [31:0] rdata;
    logic        rerr;

    // read mux; unmapped or unaligned addresses answer with an error
    always_comb begin
        rdata = 32'h0000_0000;
        rerr  = 1'b0;
        if (paddr[1:0] != 2'h0)          rerr  = 1'b1;
        else if (paddr == rrcr_pkg::OFS_CTRL) rdata = {31'h0000_0000, en_reg};
        else if (paddr == rrcr_pkg::OFS_STAT) rdata = {30'h0000_0000, pkt_ready, evt_valid};
        else if (paddr == rrcr_pkg::OFS_AIDX) rdata = {21'h00_0000, aidx_reg};
        else if (paddr == rrcr_pkg::OFS_ADAT) rdata = {28'h000_0000, atbl_mem[aidx_reg]};
        else if (hit_cb)                 rdata = cbase_reg[rslot];
        else if (hit_tb)                 rdata = {10'h000, tbase_reg[rslot]};
        else if (hit_pc)                 rdata = {16'h0000, pcnt_reg[rslot]};
        else if (hit_oc)                 rdata = ocnt_reg[rslot];
        else if (hit_sp)                 rdata = split_reg[sslot];
        else if (hit_rt)                 rdata = {28'h000_0000, rtbl_mem[paddr[9:2]]};
        else                             rerr  = 1'b1;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= ap_acc && !pready;
            pslverr <= ap_acc && !pready && rerr;
            prdata  <= (ap_acc && !pready && !pwrite) ? rdata : 32'h0000_0000;
        end
    end

    // register writes; the data port walks the aal2 table index
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            en_reg   <= 1'b0;
            aidx_reg <= 11'h000;
            for (int i = 0; i < rrcr_pkg::NCONN; i++) begin
                cbase_reg[i] <= 32'h0000_0000;
                tbase_reg[i] <= 22'h00_0000;
            end
            for (int s = 0; s < 16; s++) begin
                split_reg[s] <= 32'h0000_0000;
            end
        end else if (ap_wr && !rerr) begin
            if (paddr == rrcr_pkg::OFS_CTRL)      en_reg   <= pwdata[0];
            else if (paddr == rrcr_pkg::OFS_AIDX) aidx_reg <= pwdata[10:0];
            else if (paddr == rrcr_pkg::OFS_ADAT) aidx_reg <= aidx_reg + 11'h001;
            else if (hit_cb)                 cbase_reg[rslot] <= pwdata;
            else if (hit_tb)                 tbase_reg[rslot] <= pwdata[21:0];
            else if (hit_sp)                 split_reg[sslot] <= pwdata;
        end
    end

    // table memories carry no reset; software loads them before enabling
    always_ff @(posedge clk_sys) begin
        if (ap_wr && !rerr && paddr == rrcr_pkg::OFS_ADAT) begin
            atbl_mem[aidx_reg] <= pwdata[3:0];
        end
        if (ap_wr && !rerr && hit_rt) begin
            rtbl_mem[paddr[9:2]] <= pwdata[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    wire [15:0] pc_sel = pcnt_reg[pkt_conn];
    wire [31:0] oc_sel = ocnt_reg[pkt_conn];
    wire [21:0] tb_sel = tbase_reg[pkt_conn];

    property p_ver;
        @(posedge clk_sys) disable iff (rst)
        acc && f_ver |=> evt_valid && evt_ver;
    endproperty
    a_ver: assert property (p_ver) else $error("version flag missing");

    property p_csum;
        @(posedge clk_sys) disable iff (rst)
        acc && is_rtp && pkt_csum_err |=> evt_valid && evt_csum && !evt_aal2;
    endproperty
    a_csum: assert property (p_csum) else $error("checksum flag missing");

    property p_short;
        @(posedge clk_sys) disable iff (rst)
        // index by the slot of the short packet, the next packet may use another one
        acc && f_short |=> !chan_valid && evt_short
                           && pcnt_reg[$past(pkt_conn)] == $past(pc_sel);
    endproperty
    a_short: assert property (p_short) else $error("short packet not discarded");

    property p_sat;
        @(posedge clk_sys) disable iff (rst)
        acc && is_rtp && !pkt_rtp_en && pkt_udp_len > 16'h00FF && gen
        |=> evt_mpt == 8'hFF;
    endproperty
    a_sat: assert property (p_sat) else $error("length not saturated");

    property p_pcnt;
        @(posedge clk_sys) disable iff (rst)
        acc && pkt_aal2 |=> pcnt_reg[$past(pkt_conn)] == $past(pc_sel) + 16'h0001;
    endproperty
    a_pcnt: assert property (p_pcnt) else $error("packet count wrong");

    property p_ocnt;
        @(posedge clk_sys) disable iff (rst)
        acc && pkt_aal2 |=> ocnt_reg[$past(pkt_conn)] == $past(oc_sel) + 32'h0000_0001
                            + $past(pkt_li);
    endproperty
    a_ocnt: assert property (p_ocnt) else $error("octet count wrong");

    property p_class;
        @(posedge clk_sys) disable iff (rst)
        acc && pkt_aal2 |=> class_addr[31:10] == $past(tb_sel)
                            && class_addr[9:0] == {$past(pkt_uui), $past(pkt_li[5:1])};
    endproperty
    a_class: assert property (p_class) else $error("table address wrong");

    property p_order;
        @(posedge clk_sys) disable iff (rst)
        evt_valid && !evt_ready |=> evt_valid && !pkt_ready && $stable(evt_cur_seq);
    endproperty
    a_order: assert property (p_order) else $error("pending record disturbed");

    property p_aal2_flags;
        @(posedge clk_sys) disable iff (rst)
        evt_valid && evt_aal2 |-> !evt_loss && !evt_short && !evt_ver && !evt_csum;
    endproperty
    a_aal2_flags: assert property (p_aal2_flags) else $error("bad aal2 flag");

    c_loss:  cover property (@(posedge clk_sys) disable iff (rst) acc && f_loss);
    c_aal2:  cover property (@(posedge clk_sys) disable iff (rst) acc && pkt_aal2 && f_rep);
    c_stall: cover property (@(posedge clk_sys) disable iff (rst) evt_valid && !evt_ready);

endmodule

// *** verification/rrcr_evt_sink.sv ***
`timescale 1ns/1ps
// event queue consumer; it stalls at random so records must wait their turn
module rrcr_evt_sink (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic evt_valid,
    output logic      evt_ready
);
    integer seed = 32'hc273;
    // ready is a coin toss while a record waits, and low in reset
    always @(posedge clk_sys) begin
        if (rst) begin
            evt_ready <= 1'b0;
        end else begin
            evt_ready <= evt_valid & 1'($random(seed));
        end
    end
endmodule

// *** verification/rrcr_tb_top.sv ***
`timescale 1ns/1ps
module rrcr_tb_top;
    logic                 clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic                 pkt_valid = 1'b0, pkt_aal2 = 1'b0, pkt_rtp_en = 1'b0, pkt_marker = 1'b0;
    logic                 pkt_csum_err = 1'b0, pkt_len_short = 1'b0;
    logic [1:0]           pkt_conn = 2'h0, pkt_rtp_ver = 2'h0;
    logic [6:0]           pkt_ptype = 7'h00, ke_v;
    logic [4:0]           pkt_uui = 5'h00, evt_uui;
    logic [5:0]           pkt_li = 6'h00, evt_li;
    logic [11:0]          paddr = 12'h000;
    logic [15:0]          pkt_udp_len = 16'h0000, pkt_seq = 16'h0000, s0, evt_prev_seq, evt_cur_seq;
    logic [31:0]          pwdata = 32'h0000_0000, local_ts = 32'h0000_0000, ts, prdata;
    logic [31:0]          evt_conn_addr, evt_ts, chan_addr, class_addr;
    logic [7:0]           evt_mpt;
    logic                 pready, pslverr, pkt_ready, evt_valid, evt_ready, chan_valid;
    logic                 evt_aal2, evt_first, evt_loss, evt_report, evt_short, evt_ver, evt_csum;
    rrcr_pkg::rrcr_kind_t chan_kind;
    rrcr_pkg::rrcr_enc_t  chan_enc;
    logic [127:0]         aq[$], eq[$], cq[$];
    integer               seed = 32'hc273;
    int                   miscompares = 0, n_checks = 0;
    rrcr_top rrcr_top_inst (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .pkt_valid, .pkt_ready, .pkt_aal2, .pkt_rtp_en, .pkt_conn,
        .pkt_csum_err, .pkt_rtp_ver, .pkt_len_short, .pkt_marker, .pkt_ptype, .pkt_udp_len,
        .pkt_seq, .pkt_uui, .pkt_li, .local_ts, .evt_valid, .evt_ready, .evt_aal2, .evt_first,
        .evt_loss, .evt_report, .evt_short, .evt_ver, .evt_csum, .evt_conn_addr, .evt_mpt,
        .evt_prev_seq, .evt_cur_seq, .evt_uui, .evt_li, .evt_ts, .chan_valid, .chan_addr,
        .chan_kind, .chan_enc, .class_addr);
    rrcr_evt_sink rrcr_evt_sink_inst (.clk_sys, .rst, .evt_valid, .evt_ready);
    always #20 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [127:0] s, input logic [127:0] e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic test_done;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // one apb transfer; an idle cycle after it keeps psel from toggling twice in a step
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk_sys) penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        aq.push_back(128'(e));
        apb(a, 1'b0, 32'h0000_0000);
    endtask
    // expectations are queued before the descriptor is offered, so the monitor never waits
    task automatic send(input logic [3:0] k, input logic [1:0] c, input logic [1:0] v,
        input logic [7:0] mp, input logic [15:0] len, input logic [15:0] sq,
        input logic [10:0] ul, input logic [89:0] rec, input logic [70:0] ch);
        ts = $random(seed);
        if (rec != '0) eq.push_back(128'({rec, ts}));
        if (ch != '0) cq.push_back(128'(ch));
        {pkt_valid, pkt_aal2, pkt_rtp_en, pkt_csum_err, pkt_len_short} <= {1'b1, k};
        {pkt_conn, pkt_rtp_ver, pkt_marker, pkt_ptype, pkt_udp_len, pkt_seq, pkt_uui, pkt_li,
            local_ts} <= {c, v, mp, len, sq, ul, ts};
        do @(posedge clk_sys); while (pkt_ready !== 1'b1);
        pkt_valid <= 1'b0;
        @(posedge clk_sys);
    endtask
    // kind and encoding expected for a split whose type is i mod 8 and encoding is i
    function automatic logic [6:0] ke(input logic [3:0] i);
        logic [2:0] k;
        logic [3:0] e;
        k = (i[2:0] == 3'h7) ? 3'h3 : (i[2:0] < 3'h3) ? {1'b0, i[1:0]} : 3'h4;
        e = (i < 4'h6) ? i : (i > 4'h7 && i < 4'hD) ? i - 4'h2 : 4'hB;
        return {k, e};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // monitor: each result takes the oldest note of its kind
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk({pslverr, prdata}, aq.size() ? aq.pop_front() : 'x);
        if (evt_valid === 1'b1 && evt_ready === 1'b1)
            chk({evt_aal2, evt_first, evt_loss, evt_report, evt_short, evt_ver, evt_csum,
                evt_conn_addr, evt_mpt, evt_prev_seq, evt_cur_seq, evt_uui, evt_li, evt_ts},
                eq.size() ? eq.pop_front() : 'x);
        if (chan_valid === 1'b1)
            chk({chan_addr, chan_kind, chan_enc, class_addr},
                cq.size() ? cq.pop_front() : 'x);
    end
    initial begin
        #400_000;
        miscompares++;
        test_done;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd(rrcr_pkg::OFS_CTRL, 33'h0);
        rd(rrcr_pkg::OFS_STAT, 33'h2); // idle: intake ready, no record pending
        rd(12'h0F0, {1'b1, 32'h0}); // unmapped place is refused
        rd(12'h002, {1'b1, 32'h0});
        wr(rrcr_pkg::OFS_CBASE, 32'h1000_0040);
        wr(rrcr_pkg::OFS_CBASE + 12'h004, 32'h1000_0080);
        wr(rrcr_pkg::OFS_CBASE + 12'h008, 32'h2000_0100);
        wr(rrcr_pkg::OFS_TBASE + 12'h008, 32'h0000_0005); // table on a 1k boundary
        wr(rrcr_pkg::OFS_SPLIT + 12'h004, 32'h0000_1021);
        wr(rrcr_pkg::OFS_RTBL + 12'h214, 32'h0000_0001);
        wr(rrcr_pkg::OFS_RTBL + 12'h3FC, 32'h0000_0001);
        wr(rrcr_pkg::OFS_AIDX, 32'h0000_00C9);
        wr(rrcr_pkg::OFS_ADAT, 32'h0000_0001);
        rd(rrcr_pkg::OFS_AIDX, 33'h0CA);
        wr(rrcr_pkg::OFS_CTRL, 32'h0000_0001);
        rd(rrcr_pkg::OFS_SPLIT + 12'h004, {1'b0, 32'h0000_1021});
        s0 = 16'($random(seed));
        send(4'b0100, 2'h0, 2'h2, 8'h85, 16'h0014, s0, 11'h0, {7'b0101000, 32'h1000_0040,
            8'h85, 16'h0, s0, 11'h0}, {32'h200, 7'h02, 32'h0});
        send(4'b0110, 2'h0, 2'h1, 8'h85, 16'h0014, s0 + 16'h5, 11'h0, {7'b0011011,
            32'h1000_0040, 8'h85, s0, s0 + 16'h5, 11'h0}, {32'h200, 7'h02, 32'h0});
        send(4'b0101, 2'h0, 2'h2, 8'h85, 16'h0004, s0 + 16'h6, 11'h0, {7'b0000100,
            32'h1000_0040, 8'h85, s0 + 16'h5, s0 + 16'h6, 11'h0}, '0);
        send(4'b0000, 2'h1, 2'h2, 8'h00, 16'h012C, 16'h0, 11'h0, {7'b0101000, 32'h1000_0080,
            8'hFF, 32'h0, 11'h0}, {32'h200, 7'h02, 32'h0});
        send(4'b1000, 2'h2, 2'h2, 8'h00, 16'h0, 16'h0, 11'h0C9, {7'b1101000, 32'h2000_0100,
            8'h00, 32'h0, 11'h0C9}, {32'h200, 7'h02, 32'h0000_1464});
        rd(rrcr_pkg::OFS_PCNT + 12'h008, 33'h1);
        rd(rrcr_pkg::OFS_OCNT + 12'h008, 33'hA);
        wr(rrcr_pkg::OFS_AIDX, 32'h0000_00C9);
        wr(rrcr_pkg::OFS_ADAT, 32'h0000_0002);
        wr(rrcr_pkg::OFS_AIDX, 32'h0000_00C9);
        rd(rrcr_pkg::OFS_ADAT, 33'h2);
        // every type and encoding code; delete entries must not reach a channel
        for (int i = 0; i < 16; i++) begin
            ke_v = ke(4'(i));
            wr(rrcr_pkg::OFS_SPLIT + 12'h008, 32'((i + 1) * 256 + i * 16 + (i % 8) * 2));
            send(4'b1000, 2'h2, 2'h2, 8'h00, 16'h0, 16'h0, 11'h0C9, 90'h0, (i % 8 == 7) ? 71'h0
                : {32'((i + 1) * 32), ke_v, 32'h0000_1464});
        end
        repeat (20) @(posedge clk_sys);
        if (aq.size() + eq.size() + cq.size() != 0) miscompares++;
        test_done;
    end
endmodule
